//--- pseudowire_sublayer_parser_bench.sv
// pseudowire_sublayer_parser_bench: self-checking bench for the parser
`timescale 1ns/1ns
module pseudowire_sublayer_parser_bench;
  import pwsp_pkg::*;
  logic sys_clk, rst, inValid, inSop, inEop, regWrite, regRead;
  logic [7:0] inData, regAddr, outData, outTag;
  logic [31:0] regWdata, regRdata, rv;
  logic outValid, outSop, outEop, outAbort, outNull, teardownReq, seqGap;
  logic latencyPkt;
  logic [3:0] outChSeq;
  logic [2:0] outFlow;
  logic [2:0] flow = 3'h5;
  logic [22:0] got[$], exp[$];
  logic [15:0] seq, lastSq;
  logic [11:0] tg[10];
  logic [3:0] cnts[4] = '{4'ha, 4'h1, 4'h0, 4'hb};
  logic [7:0] bS, bN, b;
  int seed = 84;
  int miscompares, compares, cyc, haveSq, n;
  int nGap, nNull, nTd, nLat, nAb, eGap, eNull, eTd, eLat, eAb, eAcc, eDrop;
  int nEop, eEop;
  pwsp_headend i_head (.sys_clk(sys_clk), .inData(inData),
    .inValid(inValid), .inSop(inSop), .inEop(inEop));
  pwsp_parser i_dut (.sys_clk(sys_clk), .rst(rst), .inData(inData),
    .inValid(inValid), .inSop(inSop), .inEop(inEop), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .outData(outData), .outValid(outValid),
    .outSop(outSop), .outEop(outEop), .outAbort(outAbort),
    .outNull(outNull), .outTag(outTag), .outChSeq(outChSeq),
    .outFlow(outFlow), .teardownReq(teardownReq), .seqGap(seqGap),
    .latencyPkt(latencyPkt));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
    if (!rst) begin
      if (outValid === 1'b1)
        got.push_back(outSop ? {outFlow, outChSeq, outTag, outData}
                             : 23'(outData));
      if (seqGap === 1'b1) nGap++;
      if ((outNull & outEop) === 1'b1) nNull++;
      if (teardownReq === 1'b1) nTd++;
      if (latencyPkt === 1'b1) nLat++;
      if (outAbort === 1'b1) nAb++;
      if ((outValid & outEop) === 1'b1) nEop++;
    end
  end
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    @(negedge sys_clk);
    chk(regRdata, e);
  endtask : rchk
  task automatic mode(input logic [1:0] t);
    wr(RegCtrl, {26'h0, flow, t, 1'b1});
  endtask : mode
  task automatic hdr(input logic [7:0] b0, b1, input logic [15:0] sq);
    i_head.q = {b0, b1, sq[15:8], sq[7:0]};
  endtask : hdr
  task automatic seg(input logic [7:0] sync, input bit nul, input bit keep,
                     input logic [11:0] t, input int len);
    logic [7:0] v;
    for (int i = 0; i < len; i++) begin
      v = 8'($random(seed));
      if (i == 0) v = sync;
      if (i == 1) v = nul ? {3'h0, NullPidHi} : {4'h0, v[3:0]};
      if (i == 2 && nul) v = NullPidLo;
      i_head.q.push_back(v);
      if (keep) exp.push_back(i == 0 ? {flow, t, v} : 23'(v));
    end
    if (keep && nul) eNull++;
    if (keep) eEop++;
  endtask : seg
  // fate: 1 accepted, 0 dropped, 2 bytes not compared
  task automatic go(input int fate, input bit slow);
    i_head.send(slow);
    repeat (4) @(posedge sys_clk);
    if (fate == 1) eAcc++;
    if (fate == 0) eDrop++;
    if (fate != 2) begin
      chk(32'(got.size()), 32'(exp.size()));
      foreach (exp[i]) if (i < got.size())
        chk(32'(got[i]), 32'(exp[i]));
    end
    got.delete();
    exp.delete();
    chk(nGap, eGap);
    chk(nNull, eNull);
    chk(nTd, eTd);
    chk(nLat, eLat);
    chk(nAb, eAb);
    chk(nEop, eEop);
  endtask : go
  task automatic sg(input logic [7:0] b0, input logic [15:0] sq,
                    input int cnt, input int fate, input bit slow);
    hdr(b0, 8'ha5, sq);
    for (int i = 0; i < cnt; i++) seg(TsSync, i == 3, fate == 1, 12'h0, TsLen);
    if (fate == 1 && b0[SBit]) begin
      if (haveSq != 0 && sq !== lastSq + 16'h1) eGap++;
      haveSq = 1;
      lastSq = sq;
    end
    go(fate, slow);
  endtask : sg
  initial begin
    rst = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(RegCtrl, CtrlReset);
    rchk(RegAccepted, 32'h0);
    rchk(8'h40, 32'h0);
    bS = {2'b01, 2'b00, 1'b0, flow};
    bN = {5'h0, flow};
    seq = 16'($random(seed));
    mode(PwSingle);
    rchk(RegCtrl, {26'h0, flow, PwSingle, 1'b1});
    sg(bS, seq, 1, 1, 1);
    sg(bS | 8'h08, seq + 16'h1, 7, 1, 0);
    sg(bS, seq + 16'h6, 1, 1, 0);
    sg(bS, 16'hffff, 1, 1, 0);
    sg(bS, 16'h0000, 1, 1, 0);
    sg(bN, 16'h1234, 1, 1, 0);
    sg(bS, 16'h0001, 1, 1, 0);
    sg({2'b10, 2'b00, 1'b0, flow}, 16'h0, 1, 0, 0);
    sg({4'b0010, 1'b0, flow}, 16'h0, 1, 0, 0);
    sg({4'b0011, 1'b0, flow}, 16'h0, 1, 0, 0);
    sg({5'h0, ~flow}, 16'h0, 1, 0, 0);
    mode(PwMulti);
    foreach (cnts[k]) begin
      hdr(bN, {4'h0, cnts[k]}, 16'h0);
      for (int e = 0; e < ArrayEntries; e++) begin
        tg[e] = 12'($random(seed));
        i_head.q.push_back({tg[e][11:8], 4'h0});
        i_head.q.push_back(tg[e][7:0]);
      end
      n = (cnts[k] >= 4'h1 && cnts[k] <= MaxMultiPkts) ? 1 : 0;
      for (int i = 0; i < (n ? int'(cnts[k]) : 1); i++)
        seg(TsSync, 1'b0, n == 1, tg[i], TsLen);
      go(n, k == 0);
    end
    mode(PwStream);
    hdr(bN, 8'h00, 16'h0);
    for (int i = 0; i < 40; i++) begin
      b = 8'($random(seed));
      i_head.q.push_back(b);
      exp.push_back(i == 0 ? {flow, 12'h0, b} : 23'(b));
    end
    eEop++;
    go(1, 0);
    rchk(RegAccepted, eAcc);
    rchk(RegDropped, eDrop);
    rchk(RegGaps, eGap);
    rchk(RegLastSeq, {16'h0, lastSq});
    mode(PwSingle);
    hdr(bN, 8'h00, 16'h0);
    seg(TsSync, 1'b0, 1'b0, 12'h0, 50);
    eAb++;
    go(2, 0);
    hdr({4'b0001, 1'b0, flow}, 8'h00, 16'h0);
    seg(TsSync, 1'b0, 1'b0, 12'h0, TsLen);
    eLat++;
    go(2, 0);
    hdr(bN, 8'h00, 16'h0);
    seg(8'h12, 1'b0, 1'b0, 12'h0, TsLen);
    eTd++;
    go(2, 0);
    rchk(RegStatus, 32'h1);
    sg(bN, 16'h0, 1, 0, 0);
    wr(RegStatus, 32'h1);
    rchk(RegStatus, 32'h0);
    sg(bN, 16'h0, 1, 1, 0);
    summarize();
  end
endmodule : pseudowire_sublayer_parser_bench

//--- pwsp_headend.sv
// pwsp_headend: behavioural headend core that streams packet bytes
`timescale 1ns/1ns
module pwsp_headend (
  output logic [7:0] inData,
  output logic inValid,
  output logic inSop,
  output logic inEop,
  input wire logic sys_clk
);
  logic [7:0] q[$];
  initial begin
    inData = 8'h00;
    inValid = 1'b0;
    inSop = 1'b0;
    inEop = 1'b0;
  end
  // bytes go out with no filler; slow mode idles the valid line and inverts the data for one cycle before every third byte
  task automatic send(input bit slow);
    int n;
    n = q.size();
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      if (slow && i % 3 == 2) begin
        inValid <= 1'b0;
        inSop <= 1'b0;
        inEop <= 1'b0;
        inData <= ~inData;
        @(posedge sys_clk);
      end
      inData <= q[i];
      inValid <= 1'b1;
      inSop <= (i == 0);
      inEop <= (i == n - 1);
    end
    @(posedge sys_clk);
    inValid <= 1'b0;
    inSop <= 1'b0;
    inEop <= 1'b0;
    // released line shows the inverse so stale data never looks valid
    inData <= ~q[n - 1];
  endtask : send
endmodule : pwsp_headend

//--- pwsp_parser.sv
// pwsp_parser: receive check and parse of the pseudowire sublayer header
`timescale 1ns/1ns
module pwsp_parser #(
  parameter int MaxSegs = pwsp_pkg::DefMaxSegs
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] inData,
  input wire logic inValid,
  input wire logic inSop,
  input wire logic inEop,
  input wire logic [pwsp_pkg::RegAddrW-1:0] regAddr,
  input wire logic [pwsp_pkg::RegDataW-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [pwsp_pkg::RegDataW-1:0] regRdata,
  output logic [7:0] outData,
  output logic outValid,
  output logic outSop,
  output logic outEop,
  output logic outAbort,
  output logic outNull,
  output logic [7:0] outTag,
  output logic [3:0] outChSeq,
  output logic [2:0] outFlow,
  output logic teardownReq,
  output logic seqGap,
  output logic latencyPkt
);
  import pwsp_pkg::*;

  if (MaxSegs < 1 || MaxSegs > 15) begin : g_bad_segs
    $error("MaxSegs must lie in 1..15");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_HDR, ST_ARRAY, ST_PAY, ST_SKIP
  } pwsp_state_type;

  localparam logic [3:0] SegLimit = 4'(MaxSegs);

  pwsp_state_type state;
  logic [4:0] hdrIdx;
  logic hSeqValid;
  logic hLatency;
  logic [2:0] hFlow;
  logic [3:0] pktCount;
  logic [7:0] seqHi;
  logic [7:0] tagMem [ArrayEntries];
  logic [3:0] chSeqMem [ArrayEntries];
  logic [7:0] segByte;
  logic [3:0] segCount;
  logic pidHiMatch;
  logic nullSeg;
  logic ctrlEnable;
  logic tdPending;
  logic [1:0] ctrlType;
  logic [2:0] ctrlFlow;
  logic [15:0] lastSeq;

  logic sopByte;
  logic transport;
  logic isMulti;
  logic hdrReject;
  logic countBad;
  logic segFirst;
  logic segEnd;
  logic syncBad;
  logic overflow;
  logic payByte;
  logic payStop;
  logic wrongType;
  logic abortNow;
  logic pktGood;
  logic acceptNow;
  logic dropNow;
  logic emit;
  logic seqStrobe;
  logic latNow;
  logic tdEvent;
  logic [4:0] arrOff;
  logic [3:0] eIdx;

  // outer encapsulation is already stripped: the first byte of every
  // packet is the sublayer header itself
  assign sopByte = inValid && inSop;
  assign transport = ctrlType == PwSingle || ctrlType == PwMulti;
  // both transport types use code 00; only the configured type differs
  assign isMulti = ctrlType == PwMulti;

  // reserved bit 3 is never looked at
  assign hdrReject = !ctrlEnable || tdPending || ctrlType > PwStream ||
    inData[VBit] ||
    inData[HMsb] ||
    (transport && inData[FlowMsb:0] != ctrlFlow);

  assign countBad = isMulti && !hLatency &&
    (inData[3:0] == '0 || inData[3:0] > MaxMultiPkts);

  assign segFirst = segByte == '0;
  assign segEnd = segByte == SegLast;
  // a segment that does not open with the sync byte is not transport
  // data, so the session carries another pseudowire type
  assign syncBad = transport && segFirst && inData != TsSync;
  assign overflow = transport && segFirst &&
    segCount == (isMulti ? pktCount : SegLimit);
  assign payByte = inValid && !inSop && state == ST_PAY;
  assign payStop = payByte && (overflow || syncBad);
  assign wrongType = payByte && syncBad && !overflow;
  assign tdEvent = wrongType && !tdPending;
  assign abortNow = inValid && state == ST_PAY && !segFirst &&
    (inSop || (inEop && transport && !segEnd));
  assign pktGood = !transport || (segEnd &&
    (!isMulti || 4'(segCount + 4'h1) == pktCount));
  assign acceptNow = payByte && inEop && !payStop && pktGood;
  assign dropNow = (sopByte && (hdrReject || inEop)) || payStop ||
    (inValid && !inSop && inEop &&
      (state == ST_HDR || state == ST_ARRAY ||
       (state == ST_PAY && !payStop && !pktGood))) ||
    (inValid && !inSop && state == ST_HDR &&
     hdrIdx == HdrCountPos && countBad);
  assign emit = payByte && !payStop && !abortNow;
  // the counter is trusted only when the sequence-valid bit is set
  assign seqStrobe = inValid && !inSop && !inEop && state == ST_HDR &&
    hdrIdx == HdrSeqLoPos && hSeqValid && !hLatency;
  assign latNow = inValid && !inSop && !inEop && state == ST_HDR &&
    hdrIdx == HdrSeqLoPos && hLatency;
  assign arrOff = 5'(hdrIdx - HdrLen);
  assign eIdx = arrOff[4:1];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else if (sopByte) begin
      if (inEop) begin
        state <= ST_IDLE;
      end else begin
        state <= hdrReject ? ST_SKIP : ST_HDR;
      end
    end else if (inValid) begin
      unique case (state)
        ST_IDLE: state <= ST_IDLE;
        ST_HDR: begin
          if (inEop) begin
            state <= ST_IDLE;
          end else if (hdrIdx == HdrCountPos && countBad) begin
            state <= ST_SKIP;
          end else if (hdrIdx == HdrSeqLoPos) begin
            // latency headers are recognised but not parsed here
            state <= hLatency ? ST_SKIP :
              (isMulti ? ST_ARRAY : ST_PAY);
          end
        end
        ST_ARRAY: begin
          if (inEop) begin
            state <= ST_IDLE;
          end else if (hdrIdx == ArrayEnd) begin
            state <= ST_PAY;
          end
        end
        ST_PAY: begin
          if (inEop) begin
            state <= ST_IDLE;
          end else if (payStop) begin
            state <= ST_SKIP;
          end
        end
        ST_SKIP: begin
          if (inEop) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // single-channel byte 1 is reserved and never stored
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hdrIdx <= '0;
      hSeqValid <= 1'b0;
      hLatency <= 1'b0;
      hFlow <= '0;
      pktCount <= '0;
      seqHi <= '0;
    end else if (sopByte) begin
      hdrIdx <= HdrCountPos;
      hSeqValid <= inData[SBit];
      hLatency <= inData[HMsb:HLsb] == HLatency;
      hFlow <= inData[FlowMsb:0];
    end else if (inValid && (state == ST_HDR || state == ST_ARRAY)) begin
      hdrIdx <= 5'(hdrIdx + 5'h01);
      if (hdrIdx == HdrCountPos && isMulti) begin
        pktCount <= inData[3:0];
      end
      if (hdrIdx == HdrSeqHiPos) begin
        seqHi <= inData;
      end
    end
  end

  // all ten entries are stored; those past the count are never read
  always_ff @(posedge sys_clk) begin
    if (inValid && !inSop && state == ST_ARRAY) begin
      if (!arrOff[0]) begin
        chSeqMem[eIdx] <= inData[7:4];
      end else begin
        tagMem[eIdx] <= inData;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || sopByte) begin
      segByte <= '0;
      segCount <= '0;
      pidHiMatch <= 1'b0;
      nullSeg <= 1'b0;
    end else if (payByte && !payStop) begin
      if (!transport) begin
        segByte <= StreamBusy;
      end else begin
        segByte <= segEnd ? '0 : 8'(segByte + 8'h01);
        if (segEnd) begin
          segCount <= 4'(segCount + 4'h1);
        end
        if (segByte == PidHiPos) begin
          pidHiMatch <= inData[4:0] == NullPidHi;
        end
        if (segByte == PidLoPos) begin
          nullSeg <= pidHiMatch && inData == NullPidLo;
        end
      end
    end
  end

  // transport bytes leave as they arrive, so a late fault can only be
  // signalled by aborting the open segment, never by holding it back
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      outValid <= 1'b0;
      outSop <= 1'b0;
      outEop <= 1'b0;
      outAbort <= 1'b0;
      outNull <= 1'b0;
      outData <= '0;
      outTag <= '0;
      outChSeq <= '0;
      outFlow <= '0;
      teardownReq <= 1'b0;
      latencyPkt <= 1'b0;
    end else begin
      outValid <= emit;
      outSop <= emit && segFirst;
      outEop <= emit && (transport ? segEnd : inEop);
      outNull <= emit && transport && segEnd && nullSeg;
      outAbort <= abortNow;
      teardownReq <= tdEvent;
      latencyPkt <= latNow;
      if (emit) begin
        outData <= inData;
        outFlow <= hFlow;
        outTag <= isMulti ? tagMem[segCount] : '0;
        outChSeq <= isMulti ? chSeqMem[segCount] : '0;
      end
    end
  end

  pwsp_seq_check u_seq (
    .sys_clk(sys_clk),
    .rst(rst),
    .seqStrobe(seqStrobe),
    .seqValue({seqHi, inData}),
    .seqGap(seqGap),
    .lastSeq(lastSeq)
  );

  pwsp_regs u_regs (
    .sys_clk(sys_clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdata(regRdata),
    .evAccept(acceptNow),
    .evDrop(dropNow),
    .evGap(seqGap),
    .evTeardown(tdEvent),
    .lastSeq(lastSeq),
    .ctrlEnable(ctrlEnable),
    .ctrlType(ctrlType),
    .ctrlFlow(ctrlFlow),
    .tdPending(tdPending)
  );

  logic [7:0] emitCnt;

  always_ff @(posedge sys_clk) begin
    if (rst || outAbort) begin
      emitCnt <= '0;
    end else if (outValid) begin
      emitCnt <= outEop ? '0 : 8'(emitCnt + 8'h01);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_undef_h;
    inValid && inSop && !inEop && inData[HMsb];
  endsequence
  sequence s_bad_sync;
    payByte && syncBad && !overflow && !tdPending;
  endsequence
  sequence s_lat_hdr;
    inValid && !inSop && !inEop && state == ST_HDR &&
      hdrIdx == HdrSeqLoPos && hLatency;
  endsequence

  a_undef_h_skip: assert property (s_undef_h |=> state == ST_SKIP)
    else $error("undefined header code not skipped");
  a_vccv_drop: assert property (
    inValid && inSop && inData[VBit] |=> !outValid ##1 !outValid)
    else $error("malformed header produced data");
  a_seg_length: assert property (
    outValid && outEop && transport |-> emitCnt == SegLast)
    else $error("transport segment not 188 bytes");
  a_sync_teardown: assert property (
    s_bad_sync |=> teardownReq &&
      state == ($past(inEop) ? ST_IDLE : ST_SKIP) ##1 !teardownReq)
    else $error("wrong type did not request teardown");
  a_multi_limit: assert property (
    outValid && outSop && isMulti |->
      segCount < pktCount && pktCount <= MaxMultiPkts)
    else $error("segment beyond packet count");
  a_single_limit: assert property (
    outValid && outSop && ctrlType == PwSingle |-> segCount < SegLimit)
    else $error("too many single-channel segments");
  a_flow_match: assert property (
    outValid && transport |-> outFlow == ctrlFlow)
    else $error("foreign flow forwarded");
  a_null_end: assert property (outNull |-> outValid && outEop)
    else $error("null mark off segment end");
  a_latency_skip: assert property (
    s_lat_hdr |=> latencyPkt && state == ST_SKIP)
    else $error("latency header not set aside");
endmodule : pwsp_parser

//--- pwsp_pkg.sv
// pwsp_pkg: constants shared by the pseudowire sublayer parser
package pwsp_pkg;
  localparam int RegAddrW = 8;
  localparam int RegDataW = 32;
  localparam int TsLen = 188;
  localparam logic [7:0] SegLast = 8'(TsLen - 1);
  localparam logic [7:0] TsSync = 8'h47;
  localparam logic [7:0] PidHiPos = 8'h01;
  localparam logic [7:0] PidLoPos = 8'h02;
  localparam logic [7:0] StreamBusy = 8'h01;
  localparam logic [4:0] NullPidHi = 5'h1f;
  localparam logic [7:0] NullPidLo = 8'hff;
  // header byte positions; the entry array follows the 4-byte header
  localparam logic [4:0] HdrCountPos = 5'h01;
  localparam logic [4:0] HdrSeqHiPos = 5'h02;
  localparam logic [4:0] HdrSeqLoPos = 5'h03;
  localparam logic [4:0] HdrLen = 5'h04;
  localparam logic [4:0] ArrayEnd = 5'h17;
  localparam int ArrayEntries = 10;
  localparam logic [3:0] MaxMultiPkts = 4'ha;
  localparam int DefMaxSegs = 7;
  // first header byte: V S H H X F F F
  localparam int VBit = 7;
  localparam int SBit = 6;
  localparam int HMsb = 5;
  localparam int HLsb = 4;
  localparam int FlowMsb = 2;
  localparam logic [1:0] HLatency = 2'h1;
  localparam logic [1:0] PwSingle = 2'h0;
  localparam logic [1:0] PwMulti = 2'h1;
  localparam logic [1:0] PwStream = 2'h2;
  localparam logic [7:0] RegCtrl = 8'h00;
  localparam logic [7:0] RegStatus = 8'h04;
  localparam logic [7:0] RegAccepted = 8'h08;
  localparam logic [7:0] RegDropped = 8'h0c;
  localparam logic [7:0] RegGaps = 8'h10;
  localparam logic [7:0] RegLastSeq = 8'h14;
  localparam int CtrlEnBit = 0;
  localparam int CtrlTypeLsb = 1;
  localparam int CtrlFlowLsb = 3;
  localparam int StatTdBit = 0;
  localparam logic [31:0] CtrlReset = 32'h0000_0000;
endpackage : pwsp_pkg

//--- pwsp_regs.sv
// pwsp_regs: control, status and counter registers
`timescale 1ns/1ns
module pwsp_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [pwsp_pkg::RegAddrW-1:0] regAddr,
  input wire logic [pwsp_pkg::RegDataW-1:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [pwsp_pkg::RegDataW-1:0] regRdata,
  input wire logic evAccept,
  input wire logic evDrop,
  input wire logic evGap,
  input wire logic evTeardown,
  input wire logic [15:0] lastSeq,
  output logic ctrlEnable,
  output logic [1:0] ctrlType,
  output logic [2:0] ctrlFlow,
  output logic tdPending
);
  import pwsp_pkg::*;

  logic [RegDataW-1:0] ctrl;
  logic [RegDataW-1:0] acceptCnt;
  logic [RegDataW-1:0] dropCnt;
  logic [RegDataW-1:0] gapCnt;

  assign ctrlEnable = ctrl[CtrlEnBit];
  assign ctrlType = ctrl[CtrlTypeLsb+:2];
  assign ctrlFlow = ctrl[CtrlFlowLsb+:3];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= CtrlReset;
    end else if (regWrite && regAddr == RegCtrl) begin
      ctrl <= regWdata;
    end
  end

  // a new teardown event beats a clearing write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tdPending <= 1'b0;
    end else if (evTeardown) begin
      tdPending <= 1'b1;
    end else if (regWrite && regAddr == RegStatus && regWdata[StatTdBit]) begin
      tdPending <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acceptCnt <= '0;
      dropCnt <= '0;
      gapCnt <= '0;
    end else begin
      if (evAccept) acceptCnt <= acceptCnt + 32'h1;
      if (evDrop) dropCnt <= dropCnt + 32'h1;
      if (evGap) gapCnt <= gapCnt + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !regRead) begin
      regRdata <= '0;
    end else begin
      case (regAddr)
        RegCtrl: regRdata <= ctrl;
        RegStatus: regRdata <= 32'(tdPending);
        RegAccepted: regRdata <= acceptCnt;
        RegDropped: regRdata <= dropCnt;
        RegGaps: regRdata <= gapCnt;
        RegLastSeq: regRdata <= 32'(lastSeq);
        default: regRdata <= '0;
      endcase
    end
  end
endmodule : pwsp_regs

//--- pwsp_seq_check.sv
// pwsp_seq_check: session sequence tracking and gap flag
`timescale 1ns/1ns
module pwsp_seq_check (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic seqStrobe,
  input wire logic [15:0] seqValue,
  output logic seqGap,
  output logic [15:0] lastSeq
);
  import pwsp_pkg::*;

  logic haveSeq;

  // 16-bit add wraps naturally, so max to zero is no gap
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      haveSeq <= 1'b0;
      lastSeq <= 16'h0000;
      seqGap <= 1'b0;
    end else begin
      seqGap <= seqStrobe && haveSeq &&
        seqValue != 16'(lastSeq + 16'h0001);
      if (seqStrobe) begin
        haveSeq <= 1'b1;
        lastSeq <= seqValue;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_seq_wrap_ok: assert property (
    seqStrobe && haveSeq && lastSeq == 16'hffff && seqValue == 16'h0000
    |=> !seqGap) else $error("wrap flagged as loss");
  a_seq_gap_flag: assert property (
    seqStrobe && haveSeq && seqValue != 16'(lastSeq + 16'h0001)
    |=> seqGap ##1 (seqGap == $past(seqStrobe && haveSeq)))
    else $error("sequence gap not flagged");
endmodule : pwsp_seq_check
